// ==== shared/tcg_pkg.sv ====
// constants and types for the timecode output gating block
`default_nettype none
package tcg_pkg;
    // ------------------------------------------------------------------
    // timing
    // ------------------------------------------------------------------
    localparam int unsigned CLK_HZ = 10_000_000;
    localparam int unsigned SEC_MS = 1000;
    localparam int unsigned HALF_2HZ_MS = 250;
    localparam int unsigned SEC_CYCLES_DEF = CLK_HZ / 1000 * SEC_MS;
    localparam int unsigned HALF_2HZ_CYCLES_DEF = CLK_HZ / 1000 * HALF_2HZ_MS;
    localparam logic [5:0] SEC_PER_MIN = 6'h3C;
    localparam logic [16:0] HOLD_MAX = 17'h10063;
    // ------------------------------------------------------------------
    // quality levels, rising
    // ------------------------------------------------------------------
    localparam logic [2:0] quality_invalid = 3'h0;
    localparam logic [2:0] quality_crystal_after_set = 3'h1;
    localparam logic [2:0] quality_crystal_freewheel = 3'h2;
    localparam logic [2:0] quality_crystal_syncon = 3'h3;
    localparam logic [2:0] quality_simulated = 3'h4;
    localparam logic [2:0] quality_locked_syncoff = 3'h5;
    localparam logic [2:0] quality_sync_regulated = 3'h6;
    // ------------------------------------------------------------------
    // register map and fields
    // ------------------------------------------------------------------
    localparam logic [7:0] OFS_DCF_CFG = 8'h00;
    localparam logic [7:0] OFS_DCF_HOLD = 8'h04;
    localparam logic [7:0] OFS_IRIG_CFG = 8'h08;
    localparam logic [7:0] OFS_IRIG_HOLD = 8'h0C;
    localparam logic [7:0] OFS_STATUS = 8'h10;
    localparam int unsigned F_MINQ = 0;
    localparam int unsigned F_FAULT = 3;
    localparam int unsigned F_BASE = 4;
    localparam int unsigned F_INV = 6;
    localparam int unsigned F_FMT = 8;
    localparam int unsigned F_SPEC = 16;
    localparam int unsigned F_ST_IRIG = 4;
    localparam logic [2:0] RST_MINQ = 3'h6;
    localparam logic RST_FAULT = 1'h1;
    localparam logic [16:0] RST_HOLD = 17'h00000;
    localparam logic [7:0] RST_SPEC = 8'h00;
    // ------------------------------------------------------------------
    // types
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        BASE_LOCAL = 2'h0,
        BASE_STANDARD = 2'h1,
        BASE_UTC = 2'h2
    } tcg_base_t;
    typedef enum logic [2:0] {
        FMT_B007 = 3'h0,
        FMT_B003 = 3'h1,
        FMT_B006 = 3'h2,
        FMT_B002 = 3'h3,
        FMT_C37 = 3'h4,
        FMT_AFNOR = 3'h5
    } tcg_fmt_t;
    typedef enum logic [2:0] {
        OST_NORMAL = 3'h1,
        OST_HOLD = 3'h2,
        OST_BLOCK = 3'h4
    } tcg_ost_t;
    typedef struct packed {
        tcg_ost_t st;
        logic [16:0] min_left;
        logic [5:0] sec_left;
    } tcg_out_t;
endpackage : tcg_pkg
`default_nettype wire

// ==== logic/tcg_output_gating.sv ====
// quality gating, holdover, dcf fault reaction and apb config for timecode outputs
`default_nettype none
module tcg_output_gating
    import tcg_pkg::*;
#(
    parameter int unsigned SEC_CYCLES = SEC_CYCLES_DEF,
    parameter int unsigned HALF_2HZ_CYCLES = HALF_2HZ_CYCLES_DEF
)
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // sync source and generators, same clock
    input wire logic [2:0] quality,
    input wire logic dcf_raw,
    input wire logic irig_raw,
    input wire logic [16:0] time_local,
    input wire logic [16:0] time_standard,
    input wire logic [16:0] time_utc,
    // timecode outputs
    output logic dcf_out,
    output logic irig_out,
    output logic [2:0] dcf_state,
    output logic [2:0] irig_state,
    output logic [16:0] dcf_time,
    output logic [16:0] irig_time,
    output logic [2:0] irig_format
);
    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [23:0] div_cnt;
        logic [21:0] half_cnt;
        logic two_hz;
        logic sec_tick;
        logic [2:0] dcf_minq;
        logic dcf_fault;
        logic [1:0] dcf_base;
        logic dcf_inv;
        logic [7:0] dcf_spec;
        logic [16:0] dcf_hold;
        logic [2:0] irig_minq;
        logic [1:0] irig_base;
        logic irig_inv;
        logic [2:0] irig_fmt;
        logic [7:0] irig_spec;
        logic [16:0] irig_hold;
        tcg_out_t dcf_o;
        tcg_out_t irig_o;
        logic dcf_out;
        logic irig_out;
        logic [16:0] dcf_time;
        logic [16:0] irig_time;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } tcg_state_t;

    tcg_state_t s_reg;
    tcg_state_t s_next;
    logic dcf_ok;
    logic irig_ok;
    logic wr_done;

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    // level 7 is not a defined quality, so it never passes the gate
    function automatic logic tcg_q_ok(logic [2:0] q, logic [2:0] minq);
        tcg_q_ok = (q <= quality_sync_regulated) && (q >= minq);
    endfunction : tcg_q_ok

    function automatic logic [16:0] tcg_sel_time(logic [1:0] base, logic [16:0] loc,
        logic [16:0] std, logic [16:0] utc);
        case (base)
            BASE_STANDARD: tcg_sel_time = std;
            BASE_UTC: tcg_sel_time = utc;
            default: tcg_sel_time = loc;
        endcase
    endfunction : tcg_sel_time

    function automatic logic [16:0] tcg_clamp(logic [31:0] d);
        if (d > {15'h0000, HOLD_MAX})
            tcg_clamp = HOLD_MAX;
        else
            tcg_clamp = d[16:0];
    endfunction : tcg_clamp

    function automatic logic tcg_mapped(logic [7:0] a);
        tcg_mapped = (a == OFS_DCF_CFG) || (a == OFS_DCF_HOLD) || (a == OFS_IRIG_CFG)
            || (a == OFS_IRIG_HOLD) || (a == OFS_STATUS);
    endfunction : tcg_mapped

    // holdover runs in whole minutes of sixty second ticks; the first
    // tick after entry may come early, so the span is up to 1 s short
    function automatic tcg_out_t tcg_step(tcg_out_t cur, logic ok, logic [16:0] hold,
        logic tick);
        tcg_out_t n;
        n = cur;
        if (ok)
        begin
            n.st = OST_NORMAL;
            n.min_left = hold;
            n.sec_left = SEC_PER_MIN;
        end
        else
        begin
            case (cur.st)
                OST_NORMAL:
                begin
                    if (hold == 17'h00000)
                        n.st = OST_BLOCK;
                    else
                    begin
                        n.st = OST_HOLD;
                        n.min_left = hold;
                        n.sec_left = SEC_PER_MIN;
                    end
                end
                OST_HOLD:
                begin
                    if (tick)
                    begin
                        if (cur.sec_left == 6'h01)
                        begin
                            if (cur.min_left == 17'h00001)
                                n.st = OST_BLOCK;
                            else
                            begin
                                n.min_left = cur.min_left - 17'h00001;
                                n.sec_left = SEC_PER_MIN;
                            end
                        end
                        else
                            n.sec_left = cur.sec_left - 6'h01;
                    end
                end
                OST_BLOCK:
                    n.st = OST_BLOCK;
                default:
                    n.st = OST_BLOCK;
            endcase
        end
        tcg_step = n;
    endfunction : tcg_step

    // ------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------
    assign dcf_ok = tcg_q_ok(quality, s_reg.dcf_minq);
    assign irig_ok = tcg_q_ok(quality, s_reg.irig_minq);
    assign wr_done = psel && penable && s_reg.pready && pwrite;

    always_comb
    begin
        s_next = s_reg;
        // second divider and free-running 2 Hz square wave
        s_next.sec_tick = 1'b0;
        if (s_reg.div_cnt == 24'(SEC_CYCLES - 1))
        begin
            s_next.div_cnt = 24'h000000;
            s_next.sec_tick = 1'b1;
        end
        else
            s_next.div_cnt = s_reg.div_cnt + 24'h000001;
        if (s_reg.half_cnt == 22'(HALF_2HZ_CYCLES - 1))
        begin
            s_next.half_cnt = 22'h000000;
            s_next.two_hz = ~s_reg.two_hz;
        end
        else
            s_next.half_cnt = s_reg.half_cnt + 22'h000001;
        // register writes take effect at the completing edge
        if (wr_done)
        begin
            case (paddr)
                OFS_DCF_CFG:
                begin
                    s_next.dcf_minq = pwdata[F_MINQ +: 3];
                    s_next.dcf_fault = pwdata[F_FAULT];
                    s_next.dcf_base = pwdata[F_BASE +: 2];
                    s_next.dcf_inv = pwdata[F_INV];
                    s_next.dcf_spec = pwdata[F_SPEC +: 8];
                end
                OFS_DCF_HOLD:
                    s_next.dcf_hold = tcg_clamp(pwdata);
                OFS_IRIG_CFG:
                begin
                    s_next.irig_minq = pwdata[F_MINQ +: 3];
                    s_next.irig_base = pwdata[F_BASE +: 2];
                    s_next.irig_inv = pwdata[F_INV];
                    s_next.irig_fmt = pwdata[F_FMT +: 3];
                    s_next.irig_spec = pwdata[F_SPEC +: 8];
                end
                OFS_IRIG_HOLD:
                    s_next.irig_hold = tcg_clamp(pwdata);
                default:
                    s_next.irig_hold = s_reg.irig_hold;
            endcase
        end
        // gating state per output
        s_next.dcf_o = tcg_step(s_reg.dcf_o, dcf_ok, s_reg.dcf_hold, s_reg.sec_tick);
        s_next.irig_o = tcg_step(s_reg.irig_o, irig_ok, s_reg.irig_hold, s_reg.sec_tick);
        // outputs follow the new state in the same edge, so a drop is immediate
        if (s_next.dcf_o.st != OST_BLOCK)
            s_next.dcf_out = dcf_raw ^ s_reg.dcf_inv;
        else if (s_reg.dcf_fault)
            s_next.dcf_out = s_next.two_hz ^ s_reg.dcf_inv;
        else
            s_next.dcf_out = s_reg.dcf_inv;
        if (s_next.irig_o.st != OST_BLOCK)
            s_next.irig_out = irig_raw ^ s_reg.irig_inv;
        else
            s_next.irig_out = s_reg.irig_inv;
        s_next.dcf_time = tcg_sel_time(s_reg.dcf_base, time_local, time_standard, time_utc);
        s_next.irig_time = tcg_sel_time(s_reg.irig_base, time_local, time_standard, time_utc);
        // apb: one wait state, read data latched on the same edge that raises pready
        s_next.pready = psel && penable && !s_reg.pready;
        s_next.pslverr = 1'b0;
        s_next.prdata = 32'h00000000;
        if (psel && penable && !s_reg.pready)
        begin
            s_next.pslverr = !tcg_mapped(paddr);
            case (paddr)
                OFS_DCF_CFG:
                    s_next.prdata = {8'h00, s_reg.dcf_spec, 8'h00, 1'b0, s_reg.dcf_inv,
                        s_reg.dcf_base, s_reg.dcf_fault, s_reg.dcf_minq};
                OFS_DCF_HOLD:
                    s_next.prdata = {15'h0000, s_reg.dcf_hold};
                OFS_IRIG_CFG:
                    s_next.prdata = {8'h00, s_reg.irig_spec, 5'h00, s_reg.irig_fmt, 1'b0,
                        s_reg.irig_inv, s_reg.irig_base, 1'b0, s_reg.irig_minq};
                OFS_IRIG_HOLD:
                    s_next.prdata = {15'h0000, s_reg.irig_hold};
                OFS_STATUS:
                    s_next.prdata = {25'h0000000, s_reg.irig_o.st, 1'b0, s_reg.dcf_o.st};
                default:
                    s_next.prdata = 32'h00000000;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            s_reg <= '0;
            s_reg.dcf_minq <= RST_MINQ;
            s_reg.dcf_fault <= RST_FAULT;
            s_reg.dcf_hold <= RST_HOLD;
            s_reg.dcf_spec <= RST_SPEC;
            s_reg.irig_minq <= RST_MINQ;
            s_reg.irig_hold <= RST_HOLD;
            s_reg.irig_spec <= RST_SPEC;
            s_reg.dcf_o <= '{OST_BLOCK, RST_HOLD, SEC_PER_MIN};
            s_reg.irig_o <= '{OST_BLOCK, RST_HOLD, SEC_PER_MIN};
        end
        else
            s_reg <= s_next;
    end

    assign prdata = s_reg.prdata;
    assign pready = s_reg.pready;
    assign pslverr = s_reg.pslverr;
    assign dcf_out = s_reg.dcf_out;
    assign irig_out = s_reg.irig_out;
    assign dcf_state = s_reg.dcf_o.st;
    assign irig_state = s_reg.irig_o.st;
    assign dcf_time = s_reg.dcf_time;
    assign irig_time = s_reg.irig_time;
    assign irig_format = s_reg.irig_fmt;

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    a_quality_gate_on: assert property (presetn && dcf_ok |=> dcf_state == OST_NORMAL)
        else $error("output not normal after good quality");
    a_block_at_once: assert property (!irig_ok && irig_state == OST_NORMAL
        && s_reg.irig_hold == 17'h00000 |=> irig_state == OST_BLOCK
        && irig_out == $past(s_reg.irig_inv))
        else $error("zero holdover did not block at once");
    a_hold_expiry: assert property (!dcf_ok && dcf_state == OST_HOLD && s_reg.sec_tick
        && s_reg.dcf_o.sec_left == 6'h01 && s_reg.dcf_o.min_left == 17'h00001
        |=> dcf_state == OST_BLOCK)
        else $error("holdover did not end on last second");
    a_hold_seconds: assert property (!dcf_ok && dcf_state == OST_HOLD && s_reg.sec_tick
        && s_reg.dcf_o.sec_left > 6'h01
        |=> s_reg.dcf_o.sec_left == $past(s_reg.dcf_o.sec_left) - 6'h01)
        else $error("holdover second count wrong");
    a_hold_clamped: assert property (s_reg.dcf_hold <= HOLD_MAX
        && s_reg.irig_hold <= HOLD_MAX)
        else $error("holdover setting above maximum");
    a_sec_spacing: assert property (s_reg.sec_tick
        |-> $past(s_reg.div_cnt) == 24'(SEC_CYCLES - 1))
        else $error("second tick spacing wrong");
    a_two_hz_toggle: assert property ($changed(s_reg.two_hz)
        |-> $past(s_reg.half_cnt) == 22'(HALF_2HZ_CYCLES - 1))
        else $error("2 Hz half period wrong");
    a_fault_pulse: assert property (dcf_state == OST_BLOCK && $past(s_reg.dcf_fault)
        |-> dcf_out == (s_reg.two_hz ^ $past(s_reg.dcf_inv)))
        else $error("fault pulse not on output");
    a_fault_silent: assert property (dcf_state == OST_BLOCK && !$past(s_reg.dcf_fault)
        |-> dcf_out == $past(s_reg.dcf_inv))
        else $error("silent fault output not idle");
    a_invert_pass: assert property (irig_state != OST_BLOCK
        |-> irig_out == ($past(irig_raw) ^ $past(s_reg.irig_inv)))
        else $error("output polarity wrong");
    a_utc_base: assert property ($past(s_reg.irig_base) == BASE_UTC
        |-> irig_time == $past(time_utc))
        else $error("utc time base not selected");
    a_std_base: assert property ($past(s_reg.dcf_base) == BASE_STANDARD
        |-> dcf_time == $past(time_standard))
        else $error("standard time base not selected");
endmodule : tcg_output_gating
`default_nettype wire

// ==== tb/tcg_receiver.sv ====
// slave clock stand-in that counts rising edges on a received timecode line
`default_nettype none
module tcg_receiver
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // observed line
    input wire logic clear,
    input wire logic line,
    output logic [15:0] rises
);
    logic prev;
    // ----------------------------------------------------------------
    // edge counter
    // ----------------------------------------------------------------
    // a line-break monitor only sees edges, so 2 Hz and silence differ here
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            rises <= 16'h0000;
            prev <= 1'b0;
        end
        else if (clear)
        begin
            rises <= 16'h0000;
            prev <= line;
        end
        else
        begin
            if (!prev && line)
                rises <= rises + 16'h0001;
            prev <= line;
        end
    end
endmodule : tcg_receiver
`default_nettype wire

// ==== tb/testbench.sv ====
// self-checking bench for the timecode output gating block
`default_nettype none
module testbench
    import tcg_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata;
    logic pready, pslverr, dcf_out, irig_out, dcf_raw = 0, irig_raw = 0, dcf_q = 0, irig_q = 0;
    logic [2:0] quality = 3'h6, dcf_state, irig_state, irig_format;
    logic [16:0] dcf_time, irig_time;
    logic [16:0] tw [3] = '{17'h0AAAA, 17'h15555, 17'h1F00F};
    logic [3:0] gen = 4'h0;
    logic rx_clear = 0;
    logic [15:0] rx_rises;
    int miscompares = 0, cmp_count = 0, cycles = 0;
    always #50 pclk = ~pclk;
    // ----------------------------------------------------------------
    // generator stand-in, delayed copies, timeout
    // ----------------------------------------------------------------
    always @(posedge pclk)
    begin
        gen <= gen + 4'h1;
        dcf_raw <= gen[1];
        irig_raw <= gen[0] ^ gen[2];
        dcf_q <= dcf_raw;
        irig_q <= irig_raw;
    end
    always @(posedge pclk)
    begin
        cycles = cycles + 1;
        if (cycles == 40000)
        begin
            miscompares = miscompares + 1;
            wrap_up();
        end
    end
    tcg_output_gating #(.SEC_CYCLES(20), .HALF_2HZ_CYCLES(5)) i_tcg_output_gating (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .quality(quality), .dcf_raw(dcf_raw), .irig_raw(irig_raw), .time_local(tw[0]),
        .time_standard(tw[1]), .time_utc(tw[2]), .dcf_out(dcf_out), .irig_out(irig_out),
        .dcf_state(dcf_state), .irig_state(irig_state), .dcf_time(dcf_time),
        .irig_time(irig_time), .irig_format(irig_format));
    tcg_receiver i_tcg_receiver (.pclk(pclk), .presetn(presetn), .clear(rx_clear),
        .line(dcf_out), .rises(rx_rises));
    // ----------------------------------------------------------------
    // shared tasks
    // ----------------------------------------------------------------
    task wrap_up();
        $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : wrap_up
    task chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count = cmp_count + 1;
        if (got !== exp)
        begin
            miscompares = miscompares + 1;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task cyc(input int n);
        repeat (n) @(posedge pclk);
    endtask : cyc
    task apb(input logic w, input logic [7:0] a, input logic [31:0] wd,
             output logic [31:0] rd, output logic err);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do
        begin
            @(posedge pclk);
        end
        while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, d, r, e);
    endtask : wr
    task rd_chk(input logic [7:0] a, input logic [31:0] exp, input logic eexp);
        logic [31:0] r;
        logic e;
        apb(1'b0, a, 32'h0, r, e);
        chk(r, exp);
        chk({31'h0, e}, {31'h0, eexp});
    endtask : rd_chk
    task set_q(input logic [2:0] q);
        @(posedge pclk);
        quality <= q;
        cyc(2);
    endtask : set_q
    task chk_follow(input logic inv, input logic ei);
        repeat (8)
        begin
            @(posedge pclk);
            chk({30'h0, irig_out & ei, dcf_out}, {30'h0, (irig_q ^ inv) & ei, dcf_q ^ inv});
        end
    endtask : chk_follow
    task count_rises(input logic [15:0] exp);
        @(posedge pclk);
        rx_clear <= 1'b1;
        @(posedge pclk);
        rx_clear <= 1'b0;
        cyc(41);
        chk({16'h0, rx_rises}, {16'h0, exp});
    endtask : count_rises
    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task t_reset_vals();
        rd_chk(OFS_DCF_CFG, {28'h0, RST_FAULT, RST_MINQ}, 1'b0);
        rd_chk(OFS_DCF_HOLD, {15'h0, RST_HOLD}, 1'b0);
        rd_chk(OFS_IRIG_CFG, {29'h0, RST_MINQ}, 1'b0);
        rd_chk(OFS_IRIG_HOLD, {15'h0, RST_HOLD}, 1'b0);
        rd_chk(OFS_STATUS, 32'h00000011, 1'b0);
        rd_chk(8'h14, 32'h0, 1'b1);
        rd_chk(8'h02, 32'h0, 1'b1);
    endtask : t_reset_vals
    task t_levels();
        for (int m = 0; m < 7; m++)
        begin
            wr(OFS_DCF_CFG, m);
            for (int q = 0; q < 8; q++)
            begin
                set_q(q[2:0]);
                chk({29'h0, dcf_state}, {29'h0, (q >= m && q < 7) ? OST_NORMAL : OST_BLOCK});
            end
        end
    endtask : t_levels
    task t_paths();
        set_q(quality_sync_regulated);
        for (int i = 0; i < 3; i++)
        begin
            wr(OFS_DCF_CFG, 32'h46 | (i << 4));
            wr(OFS_IRIG_CFG, 32'h46 | (i << 4));
            cyc(3);
            chk({15'h0, dcf_time}, {15'h0, tw[i]});
            chk({15'h0, irig_time}, {15'h0, tw[i]});
            chk_follow(1'b1, 1'b1);
        end
        for (int f = 0; f < 6; f++)
        begin
            wr(OFS_IRIG_CFG, 32'h06 | (f << 8));
            cyc(2);
            chk({29'h0, irig_format}, f);
        end
        wr(OFS_DCF_CFG, 32'h0E);
        cyc(2);
        chk_follow(1'b0, 1'b1);
    endtask : t_paths
    task t_fault();
        set_q(quality_locked_syncoff);
        chk({26'h0, irig_state, dcf_state}, {26'h0, OST_BLOCK, OST_BLOCK});
        count_rises(16'h0004);
        chk({31'h0, irig_out}, 32'h0);
        wr(OFS_DCF_CFG, 32'h06);
        cyc(2);
        count_rises(16'h0000);
        wr(OFS_DCF_CFG, 32'h46);
        cyc(3);
        chk({31'h0, dcf_out}, 32'h1);
        set_q(quality_sync_regulated);
        chk({29'h0, dcf_state}, {29'h0, OST_NORMAL});
        wr(OFS_DCF_CFG, 32'h0E);
    endtask : t_fault
    task t_holdover();
        int n;
        wr(OFS_DCF_HOLD, 32'h1);
        set_q(quality_locked_syncoff);
        chk({26'h0, irig_state, dcf_state}, {26'h0, OST_BLOCK, OST_HOLD});
        chk_follow(1'b0, 1'b0);
        n = 0;
        while (dcf_state !== OST_BLOCK && n < 1400)
        begin
            @(posedge pclk);
            n = n + 1;
        end
        chk({31'h0, n >= 1165 && n <= 1205}, 32'h1);
        set_q(quality_sync_regulated);
        chk({29'h0, dcf_state}, {29'h0, OST_NORMAL});
        set_q(quality_locked_syncoff);
        chk({29'h0, dcf_state}, {29'h0, OST_HOLD});
        set_q(quality_sync_regulated);
        wr(OFS_DCF_HOLD, 32'hFFFFFFFF);
        rd_chk(OFS_DCF_HOLD, {15'h0, HOLD_MAX}, 1'b0);
        wr(OFS_IRIG_HOLD, 32'h00010064);
        rd_chk(OFS_IRIG_HOLD, {15'h0, HOLD_MAX}, 1'b0);
        wr(OFS_IRIG_HOLD, {15'h0, HOLD_MAX});
        rd_chk(OFS_IRIG_HOLD, {15'h0, HOLD_MAX}, 1'b0);
        wr(OFS_STATUS, 32'h0);
        rd_chk(OFS_STATUS, 32'h00000011, 1'b0);
    endtask : t_holdover
    initial
    begin
        cyc(8);
        presetn <= 1'b1;
        t_reset_vals();
        t_levels();
        t_paths();
        t_fault();
        t_holdover();
        wrap_up();
    end
endmodule : testbench
`default_nettype wire
